// [core/evb_consts.svh]
`ifndef EVB_CONSTS_SVH
`define EVB_CONSTS_SVH
`define EVB_CLK_KHZ 40000
`define EVB_DEB_MS 20
`define EVB_TMO_MS 32
`define EVB_CNT_W 21
`define EVB_TAP_TOP 6'h00
`define EVB_TAP_BOT 6'h1f
`define EVB_TAP_MUTE 6'h20
`define EVB_TAP_POR 6'h06
`define EVB_BAL_LIM 7'sh20
`define EVB_BAL_FAR 7'sh10
`define EVB_VOL_B4 6'h05
`define EVB_VOL_B3 6'h0a
`define EVB_VOL_B2 6'h0f
`define EVB_VOL_B1 6'h14
`define EVB_VOL_B0 6'h1b
`define EVB_BAR_ALL 5'h1f
`define EVB_BAR_ONE 5'h01
`define EVB_LED_CTR 3'h2
`define EVB_LED_R1 3'h3
`define EVB_LED_R2 3'h4
`define EVB_LED_L1 3'h1
`define EVB_LED_L2 3'h0
`endif

// [core/evb_debounce.sv]
`timescale 1ns/10ps
`default_nettype none
`include "evb_consts.svh"
module evb_debounce #(
   parameter int unsigned STABLE_CYC = 1
) (
   input wire logic core_clk, // System clock
   input wire logic resetn, // Synchronous reset, active low
   input wire logic raw, // Contact input, idle high
   output logic clean_q // Debounced level
);
   logic meta_q;
   logic sync_q;
   logic [`EVB_CNT_W-1:0] cnt_q;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
      end else begin
         meta_q <= raw;
         sync_q <= meta_q;
      end
   end

   // New level accepted only after it holds for the full window
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         cnt_q <= '0;
         clean_q <= 1'b1;
      end else if (sync_q == clean_q) begin
         cnt_q <= '0;
      end else if (cnt_q == `EVB_CNT_W'(STABLE_CYC - 1)) begin
         cnt_q <= '0;
         clean_q <= sync_q;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end
endmodule : evb_debounce
`default_nettype wire

// [core/evb_pkg.sv]
package evb_pkg;
   typedef enum logic [0:0] {
      EVB_MODE_VOL = 1'b0,
      EVB_MODE_BAL = 1'b1
   } evb_mode_e;
   typedef logic [5:0] evb_tap_t;
   typedef struct packed {
      evb_tap_t left;
      evb_tap_t right;
   } evb_taps_s;
endpackage : evb_pkg

// [core/evb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "evb_consts.svh"
module evb_top import evb_pkg::*; #(
   parameter int unsigned DEB_CYC = `EVB_DEB_MS * `EVB_CLK_KHZ,
   parameter int unsigned TMO_CYC = `EVB_TMO_MS * `EVB_CLK_KHZ
) (
   input wire logic core_clk, // 40 MHz clock
   input wire logic resetn, // Synchronous reset, active low
   input wire logic encoder_phase_a, // Encoder contact A
   input wire logic encoder_phase_b, // Encoder contact B
   input wire logic mute_n, // Mute button, low when pressed
   input wire logic mode_n, // Mode button, low when pressed
   input wire logic power_down_n, // Shutdown request, active low
   input wire logic left_zero_cross, // Left terminals equal
   input wire logic right_zero_cross, // Right terminals equal
   output evb_taps_s wiper_taps, // Applied tap positions
   output logic balance_mode_lamp_oe, // Pulls lamp low when lit
   output logic [4:0] level_bar_oe // Pulls bar LEDs low when lit
);
   localparam int NIN = 5;
   logic [NIN-1:0] raw_v;
   logic [NIN-1:0] cln_v;
   logic a_c;
   logic b_c;
   logic mute_c;
   logic mode_c;
   logic pd_c;
   logic mute_prev_q;
   logic mode_prev_q;
   logic btn_lock_q;
   logic mute_ev;
   logic mode_ev;
   logic [1:0] idx_q;
   logic [1:0] idx_now;
   logic [1:0] delta;
   logic step_inc;
   logic step_dec;
   evb_mode_e mode_q;
   logic btn_mute_q;
   logic rot_mute_q;
   logic pwr_off_q;
   evb_tap_t base_q;
   logic signed [6:0] bal_q;
   logic silent;
   evb_tap_t tgt_l;
   evb_tap_t tgt_r;
   evb_tap_t pos_l;
   evb_tap_t pos_r;
   logic moved_l;
   logic moved_r;
   logic vol_mode;
   logic [2:0] lit_n;
   logic [2:0] bal_led;
   logic [4:0] bar_d;

   assign raw_v = {power_down_n, mode_n, mute_n, encoder_phase_b, encoder_phase_a};

   for (genvar i = 0; i < NIN; i++) begin : g_deb
      evb_debounce #(.STABLE_CYC(DEB_CYC)) u_deb (
         .core_clk(core_clk),
         .resetn(resetn),
         .raw(raw_v[i]),
         .clean_q(cln_v[i])
      );
   end

   assign a_c = cln_v[0];
   assign b_c = cln_v[1];
   assign mute_c = cln_v[2];
   assign mode_c = cln_v[3];
   assign pd_c = cln_v[4];
   assign vol_mode = (mode_q == EVB_MODE_VOL);

   // Quadrature position as binary count; two-state jumps are dropped
   assign idx_now = {a_c, a_c ^ b_c};
   assign delta = idx_now - idx_q;
   assign step_inc = (delta == 2'h1) && !pwr_off_q;
   assign step_dec = (delta == 2'h3) && !pwr_off_q;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         idx_q <= 2'h2; // Idle contacts decode to count 2
      end else begin
         idx_q <= idx_now;
      end
   end

   // Button edges; a press while the other is down locks both out
   assign mute_ev = mute_prev_q && !mute_c && mode_c && !btn_lock_q;
   assign mode_ev = mode_prev_q && !mode_c && mute_c && !btn_lock_q;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         mute_prev_q <= 1'b1;
         mode_prev_q <= 1'b1;
      end else begin
         mute_prev_q <= mute_c;
         mode_prev_q <= mode_c;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         btn_lock_q <= 1'b0;
      end else if (!mute_c && !mode_c) begin
         btn_lock_q <= 1'b1;
      end else if (mute_c && mode_c) begin
         btn_lock_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         pwr_off_q <= 1'b0;
      end else begin
         pwr_off_q <= !pd_c;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         mode_q <= EVB_MODE_VOL;
      end else if (mode_ev) begin
         mode_q <= vol_mode ? EVB_MODE_BAL : EVB_MODE_VOL;
      end
   end

   // Mute flags; rotation mute and button mute leave the settings intact
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         btn_mute_q <= 1'b0;
         rot_mute_q <= 1'b0;
      end else if (mute_ev) begin
         if (rot_mute_q) begin
            rot_mute_q <= 1'b0;
         end else begin
            btn_mute_q <= !btn_mute_q;
         end
      end else if (step_inc) begin
         if (btn_mute_q) begin
            btn_mute_q <= 1'b0;
         end else begin
            rot_mute_q <= 1'b0;
         end
      end else if (step_dec && vol_mode && !btn_mute_q && base_q == `EVB_TAP_BOT) begin
         rot_mute_q <= 1'b1;
      end
   end

   // Common level: the less attenuated channel; offset kept in bal_q
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         base_q <= `EVB_TAP_POR;
      end else if (vol_mode && !btn_mute_q && !rot_mute_q && !mute_ev) begin
         if (step_inc && base_q != `EVB_TAP_TOP) begin
            base_q <= base_q - 1'b1;
         end else if (step_dec && base_q != `EVB_TAP_BOT) begin
            base_q <= base_q + 1'b1;
         end
      end
   end

   // Positive offset attenuates the left channel, negative the right
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         bal_q <= 7'sh00;
      end else if (!vol_mode && !btn_mute_q && !rot_mute_q && !mute_ev) begin
         if (step_inc && bal_q != `EVB_BAL_LIM) begin
            bal_q <= bal_q + 7'sh01;
         end else if (step_dec && bal_q != -`EVB_BAL_LIM) begin
            bal_q <= bal_q - 7'sh01;
         end
      end
   end

   // Clamp at the bottom tap collapses the offset; it returns going up
   function automatic evb_tap_t tap_of(input evb_tap_t base, input logic signed [6:0] off);
      logic [6:0] sum;
      sum = {1'b0, base} + 7'(off);
      if (off == `EVB_BAL_LIM) begin
         tap_of = `EVB_TAP_MUTE;
      end else if (sum > {1'b0, `EVB_TAP_BOT}) begin
         tap_of = `EVB_TAP_BOT;
      end else begin
         tap_of = sum[5:0];
      end
   endfunction : tap_of

   assign silent = btn_mute_q || rot_mute_q || pwr_off_q;

   always_comb begin
      if (silent) begin
         tgt_l = `EVB_TAP_MUTE;
         tgt_r = `EVB_TAP_MUTE;
      end else begin
         tgt_l = tap_of(base_q, (bal_q > 7'sh00) ? bal_q : 7'sh00);
         tgt_r = tap_of(base_q, (bal_q < 7'sh00) ? -bal_q : 7'sh00);
      end
   end

   evb_wiper #(.TMO_CYC(TMO_CYC)) u_wip_l (
      .core_clk(core_clk),
      .resetn(resetn),
      .target(tgt_l),
      .zero_cross(left_zero_cross),
      .peer_moved(moved_r),
      .peer_force_en(vol_mode),
      .pos_q(pos_l),
      .moved_q(moved_l)
   );

   evb_wiper #(.TMO_CYC(TMO_CYC)) u_wip_r (
      .core_clk(core_clk),
      .resetn(resetn),
      .target(tgt_r),
      .zero_cross(right_zero_cross),
      .peer_moved(moved_l),
      .peer_force_en(vol_mode),
      .pos_q(pos_r),
      .moved_q(moved_r)
   );

   assign wiper_taps = '{left: pos_l, right: pos_r};

   // Bar length from the common level, one LED per band
   assign lit_n = 3'(base_q < `EVB_VOL_B4) + 3'(base_q < `EVB_VOL_B3)
                + 3'(base_q < `EVB_VOL_B2) + 3'(base_q < `EVB_VOL_B1)
                + 3'(base_q < `EVB_VOL_B0);

   always_comb begin
      if (bal_q == 7'sh00) begin
         bal_led = `EVB_LED_CTR;
      end else if (bal_q > 7'sh00) begin
         bal_led = (bal_q >= `EVB_BAL_FAR) ? `EVB_LED_R2 : `EVB_LED_R1;
      end else begin
         bal_led = (bal_q <= -`EVB_BAL_FAR) ? `EVB_LED_L2 : `EVB_LED_L1;
      end
   end

   always_comb begin
      if (!vol_mode) begin
         bar_d = `EVB_BAR_ONE << bal_led;
      end else if (silent) begin
         bar_d = 5'h00;
      end else begin
         bar_d = ~(`EVB_BAR_ALL << lit_n);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         balance_mode_lamp_oe <= 1'b0;
         level_bar_oe <= 5'h00;
      end else begin
         balance_mode_lamp_oe <= !vol_mode;
         level_bar_oe <= bar_d;
      end
   end

   sequence s_muted_up;
      btn_mute_q && step_inc && !mute_ev;
   endsequence

   sequence s_bottom_down;
      step_dec && vol_mode && !silent && !mute_ev && base_q == `EVB_TAP_BOT;
   endsequence

   mode_flip_a: assert property (@(posedge core_clk) disable iff (!resetn)
      mode_ev |=> mode_q != $past(mode_q) ##1 balance_mode_lamp_oe == (mode_q == EVB_MODE_BAL))
      else $error("mode did not toggle");
   por_state_a: assert property (@(posedge core_clk)
      !resetn |=> mode_q == EVB_MODE_VOL && base_q == `EVB_TAP_POR)
      else $error("reset state wrong");
   lamp_follow_a: assert property (@(posedge core_clk) disable iff (!resetn)
      mode_q == EVB_MODE_BAL |=> balance_mode_lamp_oe)
      else $error("mode lamp off in balance mode");
   rot_mute_a: assert property (@(posedge core_clk) disable iff (!resetn)
      s_bottom_down |=> rot_mute_q && tgt_l == `EVB_TAP_MUTE && tgt_r == `EVB_TAP_MUTE)
      else $error("bottom step did not mute");
   mute_cancel_a: assert property (@(posedge core_clk) disable iff (!resetn)
      s_muted_up |=> !btn_mute_q && base_q == $past(base_q))
      else $error("up step left mute on");
   dual_press_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (btn_lock_q || (!mute_c && !mode_c)) && !step_inc
      |=> $stable(btn_mute_q) && $stable(mode_q))
      else $error("locked buttons acted");
   vol_pair_a: assert property (@(posedge core_clk) disable iff (!resetn)
      step_inc && vol_mode && !silent && !mute_ev && base_q != `EVB_TAP_TOP
      |=> base_q == $past(base_q) - 6'h01 && $stable(bal_q))
      else $error("volume step not common");
endmodule : evb_top
`default_nettype wire

// [core/evb_wiper.sv]
`timescale 1ns/10ps
`default_nettype none
`include "evb_consts.svh"
module evb_wiper import evb_pkg::*; #(
   parameter int unsigned TMO_CYC = 1
) (
   input wire logic core_clk, // System clock
   input wire logic resetn, // Synchronous reset, active low
   input wire evb_tap_t target, // Wanted position
   input wire logic zero_cross, // High and low terminals equal
   input wire logic peer_moved, // Other wiper just moved
   input wire logic peer_force_en, // Volume mode couples the wipers
   output evb_tap_t pos_q, // Applied position
   output logic moved_q // One-cycle strobe per change
);
   logic pending;
   logic apply;
   logic [`EVB_CNT_W-1:0] tmr_q;

   assign pending = (target != pos_q);
   assign apply = pending && (zero_cross || tmr_q == `EVB_CNT_W'(TMO_CYC - 1));

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         pos_q <= `EVB_TAP_MUTE;
         moved_q <= 1'b0;
      end else begin
         moved_q <= apply;
         if (apply) begin
            pos_q <= target;
         end
      end
   end

   // Restart at a peer move gives the second wiper its own full window
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         tmr_q <= '0;
      end else if (!pending || apply) begin
         tmr_q <= '0;
      end else if (peer_force_en && peer_moved) begin
         tmr_q <= '0;
      end else begin
         tmr_q <= tmr_q + 1'b1;
      end
   end

   zc_apply_a: assert property (@(posedge core_clk) disable iff (!resetn)
      pending && zero_cross |=> moved_q && pos_q == $past(target))
      else $error("wiper ignored zero crossing");
   tmo_force_a: assert property (@(posedge core_clk) disable iff (!resetn)
      pending && tmr_q == `EVB_CNT_W'(TMO_CYC - 1) |=> moved_q)
      else $error("wiper timeout not forced");
   tmr_bound_a: assert property (@(posedge core_clk) disable iff (!resetn)
      tmr_q < `EVB_CNT_W'(TMO_CYC))
      else $error("wiper timer past limit");
endmodule : evb_wiper
`default_nettype wire

// [sim/evb_knob_model.sv]
`timescale 1ns/10ps
`default_nettype none
module evb_knob_model #(
   parameter int unsigned HOLD_CYC = 12
) (
   input wire logic core_clk, // Bench clock
   output logic encoder_phase_a, // Contact A, idle high
   output logic encoder_phase_b, // Contact B, idle high
   output logic mute_n, // Mute contact, low when pressed
   output logic mode_n // Mode contact, low when pressed
);
   initial begin
      encoder_phase_a = 1'b1;
      encoder_phase_b = 1'b1;
      mute_n = 1'b1;
      mode_n = 1'b1;
   end
   // Increasing count of {A,B}: 00, 01, 11, 10
   function automatic logic [1:0] next_state(input logic [1:0] s, input logic up);
      case (s)
         2'h0: next_state = up ? 2'h1 : 2'h2;
         2'h1: next_state = up ? 2'h3 : 2'h0;
         2'h3: next_state = up ? 2'h2 : 2'h1;
         default: next_state = up ? 2'h0 : 2'h3;
      endcase
   endfunction : next_state
   task automatic turn(input logic up);
      @(negedge core_clk);
      {encoder_phase_a, encoder_phase_b} = next_state({encoder_phase_a, encoder_phase_b}, up);
      repeat (HOLD_CYC) @(negedge core_clk);
   endtask : turn
   task automatic buttons(input logic mu_n, input logic mo_n);
      @(negedge core_clk);
      mute_n = mu_n;
      mode_n = mo_n;
      repeat (HOLD_CYC) @(negedge core_clk);
   endtask : buttons
endmodule : evb_knob_model
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top import evb_pkg::*; ;
   localparam int unsigned DEB = 4;
   localparam int unsigned TMO = 16;
   localparam int LIM = 60;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic power_down_n = 1'b1;
   logic left_zero_cross = 1'b0;
   logic right_zero_cross = 1'b0;
   logic encoder_phase_a;
   logic encoder_phase_b;
   logic mute_n;
   logic mode_n;
   evb_taps_s wiper_taps;
   logic balance_mode_lamp_oe;
   logic [4:0] level_bar_oe;
   int n_errors = 0;
   int comparisons = 0;
   int cyc = 0;
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end
   evb_top #(.DEB_CYC(DEB), .TMO_CYC(TMO)) dut (
      .core_clk(core_clk), .resetn(resetn), .encoder_phase_a(encoder_phase_a),
      .encoder_phase_b(encoder_phase_b), .mute_n(mute_n), .mode_n(mode_n),
      .power_down_n(power_down_n), .left_zero_cross(left_zero_cross),
      .right_zero_cross(right_zero_cross), .wiper_taps(wiper_taps),
      .balance_mode_lamp_oe(balance_mode_lamp_oe), .level_bar_oe(level_bar_oe));
   evb_knob_model #(.HOLD_CYC(3 * DEB)) knob (
      .core_clk(core_clk), .encoder_phase_a(encoder_phase_a),
      .encoder_phase_b(encoder_phase_b), .mute_n(mute_n), .mode_n(mode_n));
   task automatic results;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 10000) begin
         n_errors++;
         results();
      end
   end
   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Waits a bounded time for the wipers to reach the given positions
   task automatic taps(input logic [5:0] l, input logic [5:0] r, input int lim);
      int n;
      n = 0;
      while (wiper_taps !== {l, r} && n < lim) begin
         @(negedge core_clk);
         n++;
      end
      chk("wiper_taps", {l, r}, wiper_taps);
   endtask : taps
   task automatic out(input logic lamp, input logic [4:0] bar);
      repeat (4) @(negedge core_clk);
      chk("balance_mode_lamp_oe", 12'(lamp), 12'(balance_mode_lamp_oe));
      chk("level_bar_oe", 12'(bar), 12'(level_bar_oe));
   endtask : out
   task automatic turns(input logic up, input int k);
      repeat (k) knob.turn(up);
   endtask : turns
   task automatic press(input logic mute);
      knob.buttons(!mute, mute);
      knob.buttons(1'b1, 1'b1);
   endtask : press
   task automatic t_por;
      taps(6'h20, 6'h20, 0);
      chk("balance_mode_lamp_oe", 12'h000, 12'(balance_mode_lamp_oe));
      chk("level_bar_oe", 12'h000, 12'(level_bar_oe));
      repeat (4) @(negedge core_clk);
      taps(6'h20, 6'h20, 0);
      taps(6'h06, 6'h06, TMO + 4);
      out(1'b0, 5'h0f);
   endtask : t_por
   task automatic t_vol;
      left_zero_cross = 1'b1;
      right_zero_cross = 1'b1;
      turns(1'b1, 6);
      taps(6'h00, 6'h00, LIM);
      out(1'b0, 5'h1f);
      turns(1'b1, 1);
      taps(6'h00, 6'h00, 0);
      turns(1'b0, 1);
      taps(6'h01, 6'h01, LIM);
   endtask : t_vol
   task automatic t_bal;
      press(1'b0);
      out(1'b1, 5'h04);
      turns(1'b1, 1);
      taps(6'h02, 6'h01, LIM);
      out(1'b1, 5'h08);
      turns(1'b0, 2);
      taps(6'h01, 6'h02, LIM);
      out(1'b1, 5'h02);
      turns(1'b1, 1);
      taps(6'h01, 6'h01, LIM);
      turns(1'b1, 2);
      taps(6'h03, 6'h01, LIM);
      press(1'b0);
      out(1'b0, 5'h1f);
   endtask : t_bal
   task automatic t_floor;
      turns(1'b0, 28);
      taps(6'h1f, 6'h1d, LIM);
      turns(1'b0, 2);
      taps(6'h1f, 6'h1f, LIM);
      turns(1'b0, 1);
      taps(6'h20, 6'h20, LIM);
      turns(1'b1, 1);
      taps(6'h1f, 6'h1f, LIM);
      turns(1'b1, 3);
      taps(6'h1e, 6'h1c, LIM);
      out(1'b0, 5'h00);
      turns(1'b0, 4);
      taps(6'h20, 6'h20, LIM);
      press(1'b1);
      taps(6'h1f, 6'h1f, LIM);
      turns(1'b1, 10);
      taps(6'h17, 6'h15, LIM);
      out(1'b0, 5'h01);
   endtask : t_floor
   task automatic t_mute;
      press(1'b1);
      taps(6'h20, 6'h20, LIM);
      out(1'b0, 5'h00);
      press(1'b1);
      taps(6'h17, 6'h15, LIM);
      press(1'b1);
      taps(6'h20, 6'h20, LIM);
      turns(1'b1, 1);
      taps(6'h17, 6'h15, LIM);
   endtask : t_mute
   task automatic t_both;
      knob.buttons(1'b1, 1'b0);
      knob.buttons(1'b0, 1'b0);
      knob.buttons(1'b1, 1'b1);
      repeat (LIM) @(negedge core_clk);
      taps(6'h17, 6'h15, 0);
      out(1'b1, 5'h08);
      press(1'b0);
      out(1'b0, 5'h01);
   endtask : t_both
   task automatic t_zc;
      right_zero_cross = 1'b0;
      turns(1'b1, 1);
      taps(6'h16, 6'h15, 0);
      taps(6'h16, 6'h14, TMO + 3);
      left_zero_cross = 1'b0;
   endtask : t_zc
   task automatic t_sleep;
      power_down_n = 1'b0;
      taps(6'h20, 6'h20, LIM);
      turns(1'b1, 1);
      repeat (LIM) @(negedge core_clk);
      taps(6'h20, 6'h20, 0);
      power_down_n = 1'b1;
      taps(6'h16, 6'h14, LIM);
   endtask : t_sleep
   // Balance extremes: far thresholds, full attenuation and the clamp
   task automatic t_edge;
      left_zero_cross = 1'b1;
      right_zero_cross = 1'b1;
      press(1'b0);
      out(1'b1, 5'h08);
      turns(1'b1, 14);
      taps(6'h1f, 6'h14, LIM);
      out(1'b1, 5'h10);
      turns(1'b1, 17);
      taps(6'h20, 6'h14, LIM);
      out(1'b1, 5'h10);
      turns(1'b0, 48);
      taps(6'h14, 6'h1f, LIM);
      out(1'b1, 5'h01);
      press(1'b0);
      out(1'b0, 5'h01);
   endtask : t_edge
   initial begin
      repeat (3) @(negedge core_clk);
      resetn = 1'b1;
      t_por();
      t_vol();
      t_bal();
      t_floor();
      t_mute();
      t_both();
      t_zc();
      t_sleep();
      t_edge();
      results();
   end
endmodule : tb_top
`default_nettype wire
